// ==== design/fan_ctrl_pkg.sv ====
// Package for the thermal fan speed controller: register map, fields, resets.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package fan_ctrl_pkg;

    // ==========================================================
    // Widths
    localparam int TEMP_W = 8;
    localparam int SPEED_W = 16;
    localparam int NUM_SENSORS = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_WARN = 12'h004;
    localparam logic [11:0] OFF_ALARM = 12'h008;
    localparam logic [11:0] OFF_TRIP = 12'h00c;
    localparam logic [11:0] OFF_NOM = 12'h010;
    localparam logic [11:0] OFF_MIN = 12'h014;
    localparam logic [11:0] OFF_MAX = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01c;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h020;
    localparam logic [11:0] OFF_IRQ_EN = 12'h024;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h028;
    localparam logic [11:0] OFF_SPEED = 12'h02c;

    // ==========================================================
    // Control register fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_CFG_RST_BIT = 1;
    localparam int CTRL_TRIP_REARM_BIT = 2;

    // Status and interrupt bit positions (same layout)
    localparam int EV_WARN = 0;
    localparam int EV_ALARM = 1;
    localparam int EV_TRIP = 2;
    localparam int EV_W = 3;

    // ==========================================================
    // Reset values (degrees C, speed units)
    localparam logic [7:0] RST_WARN = 8'h28;
    localparam logic [7:0] RST_ALARM = 8'h46;
    localparam logic [7:0] RST_TRIP = 8'h50;
    localparam logic [15:0] RST_NOM = 16'h04b0;
    localparam logic [15:0] RST_MIN = 16'h0320;
    localparam logic [15:0] RST_MAX = 16'h0bb8;

    typedef enum logic {
        MODE_LINEAR,
        MODE_HYST
    } ctrl_mode_type;

    typedef struct packed {
        logic [7:0] present;
        logic [7:0][7:0] temp;
    } sensor_bus_type;

    typedef struct packed {
        logic [15:0] speed;
        logic stopped;
        logic power_off;
    } fan_cmd_type;

endpackage : fan_ctrl_pkg

// ==== design/fan_ramp_calc.sv ====
// Linear ramp from base speed to maximum speed over the warning..alarm span.
// Assumes warning below alarm; other orders give the low end point.
module fan_ramp_calc #(
    parameter int TW = 8,
    parameter int SW = 16
) (
    input wire logic [TW-1:0] temp,
    input wire logic [TW-1:0] lo_temp,
    input wire logic [TW-1:0] hi_temp,
    input wire logic [SW-1:0] lo_speed,
    input wire logic [SW-1:0] hi_speed,
    output logic [SW-1:0] speed
);
    logic [TW-1:0] span;
    logic [TW-1:0] pos;
    logic [SW-1:0] dspeed;
    logic [SW+TW-1:0] prod;
    logic [SW+TW-1:0] quot;

    assign span = hi_temp - lo_temp;
    assign pos = temp - lo_temp;
    assign dspeed = (hi_speed > lo_speed) ? hi_speed - lo_speed : '0;
    assign prod = {{TW{1'b0}}, dspeed} * {{SW{1'b0}}, pos};
    // Divider is combinational; fine at 50 MHz for these narrow widths
    assign quot = (span == '0) ? '0 : prod / {{SW{1'b0}}, span};

    always_comb begin
        if (temp <= lo_temp || hi_temp <= lo_temp) begin
            speed = lo_speed;
        end else if (temp >= hi_temp) begin
            speed = hi_speed;
        end else begin
            speed = lo_speed + quot[SW-1:0];
        end
    end
endmodule : fan_ramp_calc

// ==== design/thermal_fan_speed_controller.sv ====
// Top of the thermal fan speed controller with its APB register file.
// Assumes sensor readings arrive on pclk; fan drives and power switch follow outputs.
//
// Decided for this implementation: the placing of the registers and the APB slave port.

// Functional notes
// - In hysteresis mode the fans switch between max and base speed with hysteresis between the two points.
// - Any connected sensor at or above the trip limit switches the main power off in every mode.
// - In linear mode with all sensors below the warning limit the fans run at base speed.
// - In linear mode at or above the warning limit the speed follows the temperature linearly.
// - In linear mode above the alarm limit the fans run at maximum speed.
// - When nominal speed is below the minimum speed the fans stop (low-noise submode).
// - In low-noise submode fans stay stopped below the warning limit and act linear above it.
// - After reset or configuration reset the controller is in linear mode.
// - Default limits are 40 C warning, 70 C alarm and 80 C trip.
module thermal_fan_speed_controller #(
    parameter int NS = fan_ctrl_pkg::NUM_SENSORS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fan_ctrl_pkg::sensor_bus_type sensors,
    output fan_ctrl_pkg::fan_cmd_type fan_cmd,
    output logic irq
);

    // ==========================================================
    // Configuration registers
    logic [7:0] warn_temp_limit_q;
    logic [7:0] alarm_temp_limit_q;
    logic [7:0] trip_temp_limit_q;
    logic [15:0] nom_speed_q;
    logic [15:0] min_speed_q;
    logic [15:0] max_speed_q;
    logic hyst_hot_q;
    logic hyst_hot_d;
    logic trip_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic [2:0] ev_prev_q;
    fan_ctrl_pkg::fan_cmd_type fan_cmd_q;
    fan_ctrl_pkg::fan_cmd_type fan_cmd_d;

    // ==========================================================
    // APB decode
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;
    wire wr_ctrl = wr_en && paddr == fan_ctrl_pkg::OFF_CTRL && pstrb[0];
    wire wr_warn = wr_en && paddr == fan_ctrl_pkg::OFF_WARN && pstrb[0];
    wire wr_alarm = wr_en && paddr == fan_ctrl_pkg::OFF_ALARM && pstrb[0];
    wire wr_trip = wr_en && paddr == fan_ctrl_pkg::OFF_TRIP && pstrb[0];
    wire wr_nom = wr_en && paddr == fan_ctrl_pkg::OFF_NOM;
    wire wr_min = wr_en && paddr == fan_ctrl_pkg::OFF_MIN;
    wire wr_max = wr_en && paddr == fan_ctrl_pkg::OFF_MAX;
    wire wr_ien = wr_en && paddr == fan_ctrl_pkg::OFF_IRQ_EN && pstrb[0];
    wire wr_iclr = wr_en && paddr == fan_ctrl_pkg::OFF_IRQ_CLR && pstrb[0];
    wire cfg_reset = wr_ctrl && pwdata[fan_ctrl_pkg::CTRL_CFG_RST_BIT];
    wire rearm = wr_ctrl && pwdata[fan_ctrl_pkg::CTRL_TRIP_REARM_BIT];
    wire addr_ok = paddr[1:0] == 2'h0 && paddr <= fan_ctrl_pkg::OFF_SPEED;

    // Byte-lane merge for 16-bit speed registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // ==========================================================
    // Sensor evaluation: hottest connected sensor
    logic [7:0] hottest;
    logic any_present;
    always_comb begin
        hottest = '0;
        any_present = 1'b0;
        for (int i = 0; i < NS; i++) begin
            if (sensors.present[i]) begin
                any_present = 1'b1;
                if (sensors.temp[i] > hottest) begin
                    hottest = sensors.temp[i];
                end
            end
        end
    end

    // Swapped limit order selects hysteresis
    wire fan_ctrl_pkg::ctrl_mode_type mode = (alarm_temp_limit_q < warn_temp_limit_q) ?
        fan_ctrl_pkg::MODE_HYST : fan_ctrl_pkg::MODE_LINEAR;
    wire at_warn = any_present && hottest >= warn_temp_limit_q;
    wire over_alarm = any_present && hottest > alarm_temp_limit_q;
    wire at_alarm = any_present && hottest >= alarm_temp_limit_q;
    wire at_trip = any_present && hottest >= trip_temp_limit_q;
    wire low_noise = nom_speed_q < min_speed_q;
    wire [15:0] base_speed = low_noise ? min_speed_q : nom_speed_q;

    logic [15:0] ramp_speed;
    fan_ramp_calc #(
        .TW(8),
        .SW(16)
    ) u_ramp (
        .temp(hottest),
        .lo_temp(warn_temp_limit_q),
        .hi_temp(alarm_temp_limit_q),
        .lo_speed(base_speed),
        .hi_speed(max_speed_q),
        .speed(ramp_speed)
    );

    // ==========================================================
    // Speed decision
    always_comb begin
        hyst_hot_d = hyst_hot_q;
        fan_cmd_d.power_off = trip_q || at_trip;
        fan_cmd_d.stopped = 1'b0;
        fan_cmd_d.speed = base_speed;
        case (mode)
            fan_ctrl_pkg::MODE_HYST: begin
                // Alarm limit is the lower point here: on at or above warn, off below alarm
                if (at_warn) begin
                    hyst_hot_d = 1'b1;
                end else if (!at_alarm) begin
                    hyst_hot_d = 1'b0;
                end
                fan_cmd_d.speed = hyst_hot_d ? max_speed_q : base_speed;
                fan_cmd_d.stopped = !hyst_hot_d && low_noise;
            end
            fan_ctrl_pkg::MODE_LINEAR: begin
                hyst_hot_d = 1'b0;
                if (over_alarm) begin
                    fan_cmd_d.speed = max_speed_q;
                end else if (at_warn) begin
                    fan_cmd_d.speed = ramp_speed;
                end else if (low_noise) begin
                    fan_cmd_d.speed = '0;
                    fan_cmd_d.stopped = 1'b1;
                end else begin
                    fan_cmd_d.speed = base_speed;
                end
            end
            default: begin
                hyst_hot_d = 1'b0;
            end
        endcase
        if (fan_cmd_d.power_off) begin
            fan_cmd_d.speed = '0;
            fan_cmd_d.stopped = 1'b1;
        end
    end

    wire [2:0] ev_now = {at_trip, at_alarm, at_warn};
    wire [2:0] ev_rise = ev_now & ~ev_prev_q;

    // ==========================================================
    // Limits and speeds; config reset restores defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_temp_limit_q <= fan_ctrl_pkg::RST_WARN;
            alarm_temp_limit_q <= fan_ctrl_pkg::RST_ALARM;
            trip_temp_limit_q <= fan_ctrl_pkg::RST_TRIP;
            nom_speed_q <= fan_ctrl_pkg::RST_NOM;
            min_speed_q <= fan_ctrl_pkg::RST_MIN;
            max_speed_q <= fan_ctrl_pkg::RST_MAX;
        end else if (cfg_reset) begin
            warn_temp_limit_q <= fan_ctrl_pkg::RST_WARN;
            alarm_temp_limit_q <= fan_ctrl_pkg::RST_ALARM;
            trip_temp_limit_q <= fan_ctrl_pkg::RST_TRIP;
            nom_speed_q <= fan_ctrl_pkg::RST_NOM;
            min_speed_q <= fan_ctrl_pkg::RST_MIN;
            max_speed_q <= fan_ctrl_pkg::RST_MAX;
        end else begin
            if (wr_warn) warn_temp_limit_q <= pwdata[7:0];
            if (wr_alarm) alarm_temp_limit_q <= pwdata[7:0];
            if (wr_trip) trip_temp_limit_q <= pwdata[7:0];
            if (wr_nom) nom_speed_q <= merge16(nom_speed_q, pwdata, pstrb);
            if (wr_min) min_speed_q <= merge16(min_speed_q, pwdata, pstrb);
            if (wr_max) max_speed_q <= merge16(max_speed_q, pwdata, pstrb);
        end
    end

    // ==========================================================
    // Control state, trip latch and interrupts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hyst_hot_q <= 1'b0;
            trip_q <= 1'b0;
            fan_cmd_q <= '0;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            ev_prev_q <= '0;
        end else begin
            hyst_hot_q <= hyst_hot_d;
            fan_cmd_q <= fan_cmd_d;
            ev_prev_q <= ev_now;
            // Power stays off until software rearms below the trip limit
            if (at_trip) begin
                trip_q <= 1'b1;
            end else if (rearm) begin
                trip_q <= 1'b0;
            end
            if (wr_ien) irq_en_q <= pwdata[2:0];
            // Set wins over a clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~(wr_iclr ? pwdata[2:0] : 3'h0)) | ev_rise;
        end
    end

    assign fan_cmd = fan_cmd_q;
    assign irq = |(irq_stat_q & irq_en_q);

    // ==========================================================
    // Read path: data registered in setup, ready in access phase
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            fan_ctrl_pkg::OFF_CTRL: rd_mux = {29'h0, trip_q, 1'b0, mode == fan_ctrl_pkg::MODE_HYST};
            fan_ctrl_pkg::OFF_WARN: rd_mux = {24'h0, warn_temp_limit_q};
            fan_ctrl_pkg::OFF_ALARM: rd_mux = {24'h0, alarm_temp_limit_q};
            fan_ctrl_pkg::OFF_TRIP: rd_mux = {24'h0, trip_temp_limit_q};
            fan_ctrl_pkg::OFF_NOM: rd_mux = {16'h0, nom_speed_q};
            fan_ctrl_pkg::OFF_MIN: rd_mux = {16'h0, min_speed_q};
            fan_ctrl_pkg::OFF_MAX: rd_mux = {16'h0, max_speed_q};
            fan_ctrl_pkg::OFF_STATUS: rd_mux = {16'h0, hottest, 4'h0, hyst_hot_q, ev_now};
            fan_ctrl_pkg::OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
            fan_ctrl_pkg::OFF_IRQ_EN: rd_mux = {29'h0, irq_en_q};
            fan_ctrl_pkg::OFF_SPEED: rd_mux = {14'h0, fan_cmd_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

endmodule : thermal_fan_speed_controller

// ==== verification/fan_ctrl_chk.sv ====
// Port checker for the fan controller, bound to its top module.
// Assumes default limits and speeds hold until software writes any register.
module fan_ctrl_chk #(
    parameter int NS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fan_ctrl_pkg::sensor_bus_type sensors,
    input wire fan_ctrl_pkg::fan_cmd_type fan_cmd,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hot;
    logic wr_seen_q;
    logic wr_any;
    logic ctrl_wr;
    logic [15:0] spd;
    logic off;
    // ==========================================================
    // Helpers
    assign wr_any = wr_seen_q | (psel & penable & pwrite);
    assign ctrl_wr = psel & penable & pwrite & (paddr == fan_ctrl_pkg::OFF_CTRL);
    assign spd = fan_cmd.speed;
    assign off = fan_cmd.power_off;
    always_comb begin
        hot = 8'h00;
        for (int i = 0; i < NS; i++) begin
            if (sensors.present[i] && sensors.temp[i] > hot) begin
                hot = sensors.temp[i];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_seen_q <= 1'b0;
        end else if (psel && penable && pwrite) begin
            wr_seen_q <= 1'b1;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_trip_power_off: assert property (!wr_any && hot >= fan_ctrl_pkg::RST_TRIP |=> off)
        else $error("power not cut at trip");
    a_off_fans_stop: assert property (off |-> fan_cmd.stopped && spd == 16'h0000)
        else $error("fans run while power off");
    a_off_latched: assert property (off && !ctrl_wr && !$past(ctrl_wr) |=> off)
        else $error("power off dropped without rearm");
    // Sampled reset keeps the release edge out, where the output is still the reset zero
    a_cold_nominal: assert property (presetn && !wr_any && !off && hot < fan_ctrl_pkg::RST_WARN
        |=> spd == fan_ctrl_pkg::RST_NOM && !fan_cmd.stopped) else $error("cold speed wrong");
    a_warn_ramp_base: assert property (!wr_any && !off && hot == fan_ctrl_pkg::RST_WARN
        |=> spd == fan_ctrl_pkg::RST_NOM) else $error("ramp start wrong");
    a_ramp_inside: assert property (!wr_any && !off && hot > fan_ctrl_pkg::RST_WARN
        && hot < fan_ctrl_pkg::RST_ALARM |=> spd > fan_ctrl_pkg::RST_NOM && spd < fan_ctrl_pkg::RST_MAX)
        else $error("ramp speed out of span");
    a_alarm_full: assert property (!wr_any && !off && hot >= fan_ctrl_pkg::RST_ALARM
        && hot < fan_ctrl_pkg::RST_TRIP |=> spd == fan_ctrl_pkg::RST_MAX) else $error("alarm speed wrong");
    // Empty slots carry junk that moves every cycle, so only the hottest connected reading counts
    a_idle_steady: assert property ((presetn && !psel && $stable(hot))[*3] |-> $stable(fan_cmd))
        else $error("fan command moves with steady inputs");
    c_trip: cover property ($rose(off));
    c_stop: cover property (fan_cmd.stopped && !off);
    c_irq: cover property ($rose(irq));
endmodule : fan_ctrl_chk

bind thermal_fan_speed_controller fan_ctrl_chk #(.NS(NS)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensors(sensors), .fan_cmd(fan_cmd), .irq(irq)
);

// ==== verification/fan_plant.sv ====
// Behavioural sensor bank standing on the far side of the fan controller.
// Assumes the bench calls set_temp; slots without a sensor carry changing junk.
module fan_plant #(
    parameter logic [7:0] PRESENT = 8'h0a
) (
    input wire logic pclk,
    input wire logic presetn,
    output fan_ctrl_pkg::sensor_bus_type sensors
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0][7:0] temp_q = {8{8'h14}};
    logic [7:0] junk_q;
    // ==========================================================
    // Readings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_q <= 8'h00;
        end else begin
            junk_q <= junk_q + 8'h1d;
        end
    end
    always_comb begin
        sensors.present = PRESENT;
        for (int i = 0; i < 8; i++) begin
            // Empty slots change every cycle so a design that reads them shows it
            sensors.temp[i] = PRESENT[i] ? temp_q[i] : (8'hf0 ^ junk_q);
        end
    end
    task automatic set_temp(input int idx, input logic [7:0] t);
        @(posedge pclk);
        temp_q[idx] <= t;
    endtask : set_temp
endmodule : fan_plant

// ==== verification/tb.sv ====
// Self-checking bench for the fan controller: APB tasks and sensor steps.
// Assumes the sensor model in fan_plant and the bound port checker.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rd;
    logic err;
    fan_ctrl_pkg::sensor_bus_type sensors;
    fan_ctrl_pkg::fan_cmd_type fan_cmd;
    int fails = 0;
    int checked = 0;
    thermal_fan_speed_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sensors(sensors), .fan_cmd(fan_cmd), .irq(irq));
    fan_plant plant (.pclk(pclk), .presetn(presetn), .sensors(sensors));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_fan(input fan_ctrl_pkg::fan_cmd_type e);
        checked++;
        if (fan_cmd !== e) begin
            fails++;
            $display("wrong value fan_cmd expected %h seen %h", e, fan_cmd);
        end
    endtask : chk_fan
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask : apb
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is
    task automatic step(input logic [7:0] t, input logic [15:0] sp, input logic st, input logic po);
        fan_ctrl_pkg::fan_cmd_type e;
        e = {sp, st, po};
        plant.set_temp(3, t);
        repeat (2) @(posedge pclk);
        chk_fan(e);
    endtask : step
    // ==========================================================
    // Sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", fan_ctrl_pkg::OFF_CTRL, 32'h0);
        rchk("warn", fan_ctrl_pkg::OFF_WARN, 32'h28);
        rchk("alarm", fan_ctrl_pkg::OFF_ALARM, 32'h46);
        rchk("trip", fan_ctrl_pkg::OFF_TRIP, 32'h50);
        rchk("nom", fan_ctrl_pkg::OFF_NOM, 32'h04b0);
        rchk("min", fan_ctrl_pkg::OFF_MIN, 32'h0320);
        rchk("max", fan_ctrl_pkg::OFF_MAX, 32'h0bb8);
        $display("test defaults done");
        step(8'h1e, 16'h04b0, 1'b0, 1'b0);
        step(8'h28, 16'h04b0, 1'b0, 1'b0);
        step(8'h37, 16'h0834, 1'b0, 1'b0);
        step(8'h46, 16'h0bb8, 1'b0, 1'b0);
        step(8'h4b, 16'h0bb8, 1'b0, 1'b0);
        step(8'h50, 16'h0000, 1'b1, 1'b1);
        step(8'h1e, 16'h0000, 1'b1, 1'b1);
        apb(1'b1, fan_ctrl_pkg::OFF_CTRL, 32'h4);
        step(8'h1e, 16'h04b0, 1'b0, 1'b0);
        $display("test linear and trip done");
        apb(1'b1, fan_ctrl_pkg::OFF_IRQ_CLR, 32'h7);
        apb(1'b1, fan_ctrl_pkg::OFF_IRQ_EN, 32'h1);
        rchk("irq stat", fan_ctrl_pkg::OFF_IRQ_STAT, 32'h0);
        step(8'h2d, 16'h05dc, 1'b0, 1'b0);
        irq_is(1'b1);
        apb(1'b1, fan_ctrl_pkg::OFF_IRQ_EN, 32'h0);
        irq_is(1'b0);
        apb(1'b1, fan_ctrl_pkg::OFF_IRQ_EN, 32'h1);
        irq_is(1'b1);
        apb(1'b1, fan_ctrl_pkg::OFF_IRQ_CLR, 32'h1);
        irq_is(1'b0);
        rchk("unmapped", 12'h030, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        $display("test interrupt done");
        apb(1'b1, fan_ctrl_pkg::OFF_NOM, 32'h0200);
        plant.set_temp(3, 8'h1e);
        repeat (2) @(posedge pclk);
        chk("stopped", 32'h1, {31'h0, fan_cmd.stopped});
        step(8'h28, 16'h0320, 1'b0, 1'b0);
        step(8'h46, 16'h0bb8, 1'b0, 1'b0);
        $display("test low noise done");
        apb(1'b1, fan_ctrl_pkg::OFF_NOM, 32'h04b0);
        step(8'h1e, 16'h04b0, 1'b0, 1'b0);
        apb(1'b1, fan_ctrl_pkg::OFF_ALARM, 32'h23);
        rchk("ctrl", fan_ctrl_pkg::OFF_CTRL, 32'h1);
        step(8'h26, 16'h04b0, 1'b0, 1'b0);
        step(8'h28, 16'h0bb8, 1'b0, 1'b0);
        step(8'h26, 16'h0bb8, 1'b0, 1'b0);
        step(8'h22, 16'h04b0, 1'b0, 1'b0);
        $display("test hysteresis done");
        apb(1'b1, fan_ctrl_pkg::OFF_CTRL, 32'h2);
        rchk("alarm", fan_ctrl_pkg::OFF_ALARM, 32'h46);
        rchk("ctrl", fan_ctrl_pkg::OFF_CTRL, 32'h0);
        step(8'h37, 16'h0834, 1'b0, 1'b0);
        rchk("status", fan_ctrl_pkg::OFF_STATUS, 32'h00003701);
        rchk("speed", fan_ctrl_pkg::OFF_SPEED, 32'h000020d0);
        $display("test config reset done");
        finish_test();
    end
endmodule : tb
